/* smct_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R1 - Strobe positions count whole bus clocks; wait values sampled at access start.
// R2 - Address becomes valid on the same edge that bank select falls.
// R3 - Read: output enable stays high for read lead cycles after select falls.
// R4 - Read: output enable low for read wait minus read lead plus one.
// R5 - Read: byte-lane strobes track output enable exactly.
// R6 - Read end: bank select rises with output enable and byte lanes.
// R7 - Read: address held one more cycle after strobes rise.
// R8 - Write: data driven in the cycle bank select falls.
// R9 - Write: write enable falls write lead plus one cycles after select.
// R10 - Write: write enable low for write wait minus write lead plus one.
// R11 - Write: byte-lane strobes follow write enable in delay and width.
// R12 - Write: address and data held one cycle after write enable rises.
// R13 - Write: address and data held one cycle after byte lanes rise.
// R14 - Four timing counts stored separately for each of four banks.
// R15 - Reset driver holds reset low at least the minimum width; the testbench holds it low for four clocks.
// R16 - Software keeps wait counts no smaller than lead counts.
module smct_top
	import smct_pkg::*;
(
	input  wire logic              i_core_clk,
	input  wire logic              i_nrst,
	input  wire logic [AVS_W-1:0]  i_avs_address,
	input  wire logic              i_avs_read,
	input  wire logic              i_avs_write,
	input  wire logic [31:0]       i_avs_writedata,
	input  wire logic [3:0]        i_avs_byteenable,
	output logic      [31:0]       o_avs_readdata,
	output logic                   o_avs_waitrequest,
	input  wire logic              i_req_valid,
	input  wire smct_req_s         i_req,
	output logic                   o_req_ready,
	output logic                   o_rsp_valid,
	output logic      [DATA_W-1:0] o_rsp_rdata,
	output smct_mem_s              o_mem,
	input  wire logic [DATA_W-1:0] i_mem_rdata
);
	// ----------------------------------------
	// Helper functions
	// ----------------------------------------
	// Active strobe width, never below one cycle if software misprograms.
	function automatic logic [WID_W-1:0] strobe_width(
		input logic [WAIT_W-1:0] wait_c,
		input logic [WAIT_W-1:0] lead_c
	);
		if (wait_c >= lead_c) begin
			strobe_width = WID_W'({1'b0, wait_c} - {1'b0, lead_c} + 6'h01);
		end else begin
			strobe_width = 6'h01;
		end
	endfunction : strobe_width

	function automatic logic [3:0] cfg_index(
		input logic [BANK_W-1:0] bank,
		input logic [1:0]        kind
	);
		cfg_index = {bank, kind};
	endfunction : cfg_index

	// ----------------------------------------
	// Register file and bus slave
	// ----------------------------------------
	logic [WAIT_W-1:0] cfg_reg [16];
	logic              ack_reg;
	logic [31:0]       rdata_reg;
	logic [DATA_W-1:0] last_rd_reg;
	smct_state_e       state_reg;
	logic [BANK_W-1:0] bank_reg;
	logic              wr_reg;

	// One wait state: each access ends in the cycle after it starts.
	wire       bus_req  = i_avs_read | i_avs_write;
	wire       bus_done = bus_req & ack_reg;
	wire       is_cfg   = i_avs_address < OFS_CFG_END;
	wire [3:0] cfg_sel  = i_avs_address[5:2];
	wire       cfg_we   = bus_done & i_avs_write & is_cfg & i_avs_byteenable[0];
	wire [31:0] status_word = {28'h0000000, wr_reg, bank_reg,
		state_reg != S_IDLE};
	wire [31:0] rd_mux = is_cfg ? {27'h0000000, cfg_reg[cfg_sel]} :
		(i_avs_address == OFS_STATUS) ? status_word :
		(i_avs_address == OFS_RDATA) ? last_rd_reg : 32'h00000000;
	assign o_avs_waitrequest = bus_req & ~ack_reg;
	assign o_avs_readdata    = rdata_reg;

	// Acknowledge and read data capture.
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ack_reg   <= 1'b0;
			rdata_reg <= 32'h00000000;
		end else begin
			ack_reg   <= bus_req & ~ack_reg;
			rdata_reg <= rd_mux;
		end
	end

	// Per-bank timing words; unmapped writes are dropped.
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			for (int i = 0; i < 16; i++) begin
				cfg_reg[i] <= WAIT_RST;
			end
		end else if (cfg_we) begin
			cfg_reg[cfg_sel] <= i_avs_writedata[WAIT_W-1:0]; // [R14]
		end
	end

	// ----------------------------------------
	// Access sequencer
	// ----------------------------------------
	logic [WAIT_W-1:0] lead_reg;
	logic [WID_W-1:0]  width_reg;
	logic [WID_W-1:0]  cnt_reg;
	logic [BE_W-1:0]   be_reg;
	smct_mem_s         mem_reg;
	logic              rsp_reg;
	logic [DATA_W-1:0] rsp_data_reg;

	wire accept = i_req_valid & (state_reg == S_IDLE);
	wire [1:0] lk = i_req.write ? KIND_WR_LEAD : KIND_RD_LEAD;
	wire [1:0] wk = i_req.write ? KIND_WR_WAIT : KIND_RD_WAIT;
	wire [WAIT_W-1:0] new_lead = cfg_reg[cfg_index(i_req.bank, lk)]; // [R14]
	wire [WAIT_W-1:0] new_wait = cfg_reg[cfg_index(i_req.bank, wk)];
	// Write strobes start one cycle later than read strobes.
	wire [WID_W-1:0] lead_len = {1'b0, new_lead} + {5'h00, i_req.write}; // [R3] [R9]
	wire [NBANK-1:0] cs_sel = NBANK'(1) << i_req.bank;
	wire cnt_zero = cnt_reg == 6'h00;
	assign o_req_ready = state_reg == S_IDLE;
	assign o_mem       = mem_reg;
	assign o_rsp_valid = rsp_reg;
	assign o_rsp_rdata = rsp_data_reg;

	// State, counters and pin drive, all from flip-flops.
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_reg    <= S_IDLE;
			cnt_reg      <= 6'h00;
			lead_reg     <= WAIT_RST;
			width_reg    <= 6'h01;
			be_reg       <= 4'h0;
			bank_reg     <= 2'h0;
			wr_reg       <= 1'b0;
			rsp_reg      <= 1'b0;
			rsp_data_reg <= 32'h00000000;
			last_rd_reg  <= 32'h00000000;
			mem_reg      <= '{addr: '0, wdata: '0, data_oe: 1'b0,
				cs_n: 4'hf, oe_n: 1'b1, we_n: 1'b1, byte_lane_strobe_n: 4'hf};
		end else begin
			rsp_reg <= 1'b0;
			unique case (state_reg)
				S_IDLE: begin
					if (accept) begin
						// Timing words are latched once per access.
						lead_reg  <= new_lead; // [R1]
						width_reg <= strobe_width(new_wait, new_lead); // [R4] [R10] [R16]
						be_reg    <= i_req.be;
						bank_reg  <= i_req.bank;
						wr_reg    <= i_req.write;
						mem_reg.cs_n    <= ~cs_sel; // [R2]
						mem_reg.addr    <= i_req.addr; // [R2]
						mem_reg.wdata   <= i_req.wdata; // [R8]
						mem_reg.data_oe <= i_req.write; // [R8]
						if (lead_len == 6'h00) begin
							// Zero read lead: strobes fall with bank select.
							mem_reg.oe_n <= 1'b0; // [R3]
							mem_reg.byte_lane_strobe_n <= ~i_req.be; // [R5]
							cnt_reg   <= strobe_width(new_wait, new_lead) - 6'h01;
							state_reg <= S_STROBE;
						end else begin
							cnt_reg   <= lead_len - 6'h01;
							state_reg <= S_LEAD;
						end
					end
				end
				S_LEAD: begin
					if (cnt_zero) begin
						mem_reg.oe_n <= wr_reg; // [R3]
						mem_reg.we_n <= ~wr_reg; // [R9]
						mem_reg.byte_lane_strobe_n <= ~be_reg; // [R5] [R11]
						cnt_reg   <= width_reg - 6'h01;
						state_reg <= S_STROBE;
					end else begin
						cnt_reg <= cnt_reg - 6'h01;
					end
				end
				S_STROBE: begin
					if (cnt_zero) begin
						// Select and strobes rise together on one edge.
						mem_reg.oe_n <= 1'b1; // [R6]
						mem_reg.we_n <= 1'b1; // [R10]
						mem_reg.byte_lane_strobe_n <= 4'hf; // [R5] [R11]
						mem_reg.cs_n <= 4'hf; // [R6]
						if (!wr_reg) begin
							rsp_data_reg <= i_mem_rdata;
							last_rd_reg  <= i_mem_rdata;
						end
						state_reg <= S_HOLD;
					end else begin
						cnt_reg <= cnt_reg - 6'h01;
					end
				end
				S_HOLD: begin
					// Address and data stood one cycle past the strobes.
					mem_reg.data_oe <= 1'b0; // [R7] [R12] [R13]
					rsp_reg   <= 1'b1;
					state_reg <= S_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	logic [WID_W-1:0] since_cs_h;
	logic [WID_W-1:0] slen_h;
	wire strobe_low_h = ~mem_reg.oe_n | ~mem_reg.we_n;

	// Cycles since bank select fell and length of current strobe.
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			since_cs_h <= 6'h00;
			slen_h     <= 6'h00;
		end else begin
			since_cs_h <= accept ? 6'h00 : since_cs_h + 6'h01;
			slen_h     <= strobe_low_h ? slen_h + 6'h01 : 6'h00;
		end
	end

	a_start_cs_addr: assert property (@(posedge i_core_clk) disable iff (!i_nrst) // [R2]
		accept |=> !o_mem.cs_n[$past(i_req.bank)] && o_mem.addr == $past(i_req.addr))
		else $error("Select and address not presented together");
	a_sample_once: assert property (@(posedge i_core_clk) disable iff (!i_nrst) // [R1]
		(state_reg != S_IDLE) |=> $stable(lead_reg) && $stable(width_reg))
		else $error("Timing words changed during an access");
	a_bank_words: assert property (@(posedge i_core_clk) disable iff (!i_nrst) // [R14]
		accept |=> lead_reg == $past(new_lead))
		else $error("Lead taken from wrong bank word");
	a_read_lead: assert property (@(posedge i_core_clk) disable iff (!i_nrst) // [R3]
		$fell(o_mem.oe_n) |-> since_cs_h == {1'b0, lead_reg})
		else $error("Read strobe lead wrong");
	a_read_width: assert property (@(posedge i_core_clk) disable iff (!i_nrst) // [R4]
		$rose(o_mem.oe_n) |-> $past(slen_h) == width_reg - 6'h01)
		else $error("Read strobe width wrong");
	a_read_lanes: assert property (@(posedge i_core_clk) disable iff (!i_nrst) // [R5]
		(!wr_reg && state_reg != S_IDLE) |->
		o_mem.byte_lane_strobe_n == (o_mem.oe_n ? 4'hf : ~be_reg))
		else $error("Byte lanes differ from output enable");
	a_read_cs_end: assert property (@(posedge i_core_clk) disable iff (!i_nrst) // [R6]
		$rose(o_mem.oe_n) |-> &o_mem.cs_n)
		else $error("Select did not rise with output enable");
	a_read_addr_hold: assert property (@(posedge i_core_clk) disable iff (!i_nrst) // [R7]
		$rose(o_mem.oe_n) |-> $stable(o_mem.addr) && !o_req_ready)
		else $error("Read address not held");
	a_write_data: assert property (@(posedge i_core_clk) disable iff (!i_nrst) // [R8]
		(accept && i_req.write) |=> o_mem.data_oe && o_mem.wdata == $past(i_req.wdata))
		else $error("Write data not driven with select");
	a_write_lead: assert property (@(posedge i_core_clk) disable iff (!i_nrst) // [R9]
		$fell(o_mem.we_n) |-> since_cs_h == {1'b0, lead_reg} + 6'h01)
		else $error("Write strobe lead wrong");
	a_write_width: assert property (@(posedge i_core_clk) disable iff (!i_nrst) // [R10]
		$rose(o_mem.we_n) |-> $past(slen_h) == width_reg - 6'h01)
		else $error("Write strobe width wrong");
	a_write_lanes: assert property (@(posedge i_core_clk) disable iff (!i_nrst) // [R11]
		(wr_reg && state_reg != S_IDLE) |->
		o_mem.byte_lane_strobe_n == (o_mem.we_n ? 4'hf : ~be_reg))
		else $error("Byte lanes differ from write enable");
	a_write_hold: assert property (@(posedge i_core_clk) disable iff (!i_nrst) // [R12] [R13]
		$rose(o_mem.we_n) |-> o_mem.data_oe && $stable(o_mem.wdata) && $stable(o_mem.addr))
		else $error("Write address or data not held");

	// ----------------------------------------
	// Bus slave and pin sanity checks
	// ----------------------------------------
	a_cfg_write_lands: assert property (@(posedge i_core_clk) disable iff (!i_nrst) // [R14]
		cfg_we |=> cfg_reg[$past(cfg_sel)] == $past(i_avs_writedata[WAIT_W-1:0]))
		else $error("Timing word write did not land");
	a_bus_one_wait: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
		o_avs_waitrequest |=> !o_avs_waitrequest || !(i_avs_read || i_avs_write))
		else $error("Register access took more than one wait state");
	a_one_bank_select: assert property (@(posedge i_core_clk) disable iff (!i_nrst) // [R2]
		$onehot0(~o_mem.cs_n))
		else $error("More than one bank selected");
	a_strobes_exclusive: assert property (@(posedge i_core_clk) disable iff (!i_nrst) // [R3] [R9]
		!(!o_mem.oe_n && !o_mem.we_n))
		else $error("Output enable and write enable low together");
	a_rsp_one_pulse: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
		o_rsp_valid |=> !o_rsp_valid)
		else $error("End of access pulse longer than one cycle");
	a_idle_pins_high: assert property (@(posedge i_core_clk) disable iff (!i_nrst) // [R6]
		(state_reg == S_IDLE) |-> &o_mem.cs_n && o_mem.oe_n && o_mem.we_n)
		else $error("Memory strobes active while idle");
	a_write_data_release: assert property (@(posedge i_core_clk) disable iff (!i_nrst) // [R13]
		$rose(o_mem.we_n) |=> !o_mem.data_oe)
		else $error("Data bus not released after hold cycle");
	a_read_no_drive: assert property (@(posedge i_core_clk) disable iff (!i_nrst) // [R8]
		(!wr_reg && state_reg != S_IDLE) |-> !o_mem.data_oe)
		else $error("Data bus driven during a read");
endmodule : smct_top
`default_nettype wire

/* smct_pkg.sv */
`default_nettype none
package smct_pkg;
	// ----------------------------------------
	// Widths and sizes
	// ----------------------------------------
	localparam int NBANK  = 4;
	localparam int BANK_W = 2;
	localparam int WAIT_W = 5;
	localparam int WID_W  = WAIT_W + 1;
	localparam int ADDR_W = 24;
	localparam int DATA_W = 32;
	localparam int BE_W   = 4;
	localparam int AVS_W  = 8;
	// Reset minimum width in milliseconds; the testbench holds reset low for four clocks.
	localparam int RESET_MIN_MS = 10;
	// Bus clock period in nanoseconds.
	localparam int CLK_PERIOD_NS = 40;

	// ----------------------------------------
	// Register map, byte addresses
	// ----------------------------------------
	// Bank timing words sit at (bank * 4 + kind) * 4.
	localparam logic [1:0] KIND_RD_LEAD = 2'h0;
	localparam logic [1:0] KIND_RD_WAIT = 2'h1;
	localparam logic [1:0] KIND_WR_LEAD = 2'h2;
	localparam logic [1:0] KIND_WR_WAIT = 2'h3;
	localparam logic [AVS_W-1:0] OFS_STATUS = 8'h40;
	localparam logic [AVS_W-1:0] OFS_RDATA  = 8'h44;
	localparam logic [AVS_W-1:0] OFS_CFG_END = 8'h40;
	localparam int ST_BUSY_BIT  = 0;
	localparam int ST_BANK_LSB  = 1;
	localparam int ST_WRITE_BIT = 3;
	localparam logic [WAIT_W-1:0] WAIT_RST = 5'h00;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		S_IDLE   = 2'b00,
		S_LEAD   = 2'b01,
		S_STROBE = 2'b10,
		S_HOLD   = 2'b11
	} smct_state_e;

	typedef struct packed {
		logic              write;
		logic [BANK_W-1:0] bank;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [BE_W-1:0]   be;
	} smct_req_s;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              data_oe;
		logic [NBANK-1:0]  cs_n;
		logic              oe_n;
		logic              we_n;
		logic [BE_W-1:0]   byte_lane_strobe_n;
	} smct_mem_s;
endpackage : smct_pkg
`default_nettype wire

/* smct_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module smct_mem_model
	import smct_pkg::*;
(
	input  wire logic              i_core_clk,
	input  wire smct_mem_s         i_mem,
	output logic      [DATA_W-1:0] o_rdata
);
	// ----------------------------------------
	// Static memory stand-in
	// ----------------------------------------
	logic [DATA_W-1:0] junk_reg = 32'h0f0f_0f0f;
	wire               drive    = ~i_mem.oe_n & ~&i_mem.cs_n & ~i_mem.data_oe;

	// A released bus shows a pattern that changes every cycle, never stale data.
	always @(posedge i_core_clk) begin
		junk_reg <= ~junk_reg ^ 32'h1;
	end

	// Selected and output-enabled, the device returns a word made from its address.
	assign o_rdata = drive ? {8'ha5, i_mem.addr} : junk_reg;
endmodule : smct_mem_model
`default_nettype wire

/* smct_top_test.sv */
`timescale 1ns/1ps
`default_nettype none
module smct_top_test;
	import smct_pkg::*;
	// ----------------------------------------
	// Stimulus, monitor and checks
	// ----------------------------------------
	typedef struct packed {
		logic       wr;
		logic [1:0] bank;
		logic [3:0] be;
		logic [5:0] lead;
		logic [5:0] wid;
	} smct_row_s;
	smct_row_s   rows [8] = '{'{0,0,4'hf,0,1}, '{1,0,4'h1,4,1}, '{0,1,4'h3,1,3},
		'{1,1,4'hc,3,3}, '{0,2,4'h8,2,5}, '{1,2,4'h6,2,5}, '{0,3,4'h5,3,7}, '{1,3,4'ha,1,7}};
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic [7:0]  av_a = 8'h00;
	logic        av_rd = 1'b0;
	logic        av_wr = 1'b0;
	logic [31:0] av_d = 32'h0;
	logic [31:0] av_q, q, rs_d, m_d;
	logic        av_wait, rq_rdy, rs_v, ok, stb;
	logic        rq_v = 1'b0;
	logic        tail = 1'b0;
	smct_req_s   rq = '0;
	smct_mem_s   mem;
	int          failures = 0;
	int          checks_done = 0;
	int          cyc, fall, wid;

	// Clock at 25 MHz.
	always #20 clk = ~clk;

	smct_top smct_top_inst (.i_core_clk(clk), .i_nrst(nrst), .i_avs_address(av_a),
		.i_avs_read(av_rd), .i_avs_write(av_wr), .i_avs_writedata(av_d),
		.i_avs_byteenable(4'hf), .o_avs_readdata(av_q), .o_avs_waitrequest(av_wait),
		.i_req_valid(rq_v), .i_req(rq), .o_req_ready(rq_rdy), .o_rsp_valid(rs_v),
		.o_rsp_rdata(rs_d), .o_mem(mem), .i_mem_rdata(m_d));
	smct_mem_model smct_mem_model_inst (.i_core_clk(clk), .i_mem(mem), .o_rdata(m_d));

	task cmp(input string what, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("unexpected %s expected %h seen %h", what, e, g);
		end
	endtask : cmp

	task wrap_up;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : wrap_up

	// Avalon master: holds the request until waitrequest is seen low.
	task av(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		av_a <= a;
		av_wr <= wr;
		av_rd <= ~wr;
		av_d <= d;
		for (n = 0; n < 20; n++) begin
			@(posedge clk);
			if (av_wait === 1'b0) break;
		end
		if (n == 20) begin
			failures++;
			wrap_up;
		end
		q = av_q;
		av_rd <= 1'b0;
		av_wr <= 1'b0;
	endtask : av

	// One memory access, waiting for the end-of-access pulse.
	task acc(input logic wr, input logic [1:0] b, input logic [3:0] be, input logic [23:0] a);
		int n, m;
		@(posedge clk);
		rq_v <= 1'b1;
		rq <= '{wr, b, a, {~a[7:0], a}, be};
		for (n = 0; n < 10; n++) begin
			@(negedge clk);
			if (rq_rdy === 1'b1) break;
		end
		@(posedge clk);
		rq_v <= 1'b0;
		for (m = 0; m < 100; m++) begin
			@(negedge clk);
			if (rs_v === 1'b1) break;
		end
		if (n == 10 || m == 100) begin
			failures++;
			wrap_up;
		end
	endtask : acc

	function automatic logic [31:0] wordv(input int i);
		int b;
		b = i / 4;
		case (i % 4)
			0: return b;
			1: return 3 * b;
			2: return 3 - b;
			default: return 3 + b;
		endcase
	endfunction : wordv

	// Watches the memory pins cycle by cycle and measures strobe lead and width.
	always @(posedge clk) begin
		stb = mem.oe_n === 1'b0 || mem.we_n === 1'b0;
		if (!nrst || rs_v === 1'b1) begin
			cyc = 0;
			fall = -1;
			wid = 0;
			tail = 1'b0;
		end else if (mem.cs_n !== 4'hf) begin
			if (stb) begin
				if (fall < 0) fall = cyc;
				wid++;
			end else if (fall >= 0) cmp("select after strobe", 0, 1);
			ok = mem.addr === rq.addr && mem.cs_n === ~(4'h1 << rq.bank)
				&& mem.byte_lane_strobe_n === (stb ? ~rq.be : 4'hf);
			ok = ok && (rq.write ? mem.oe_n === 1'b1 && mem.data_oe === 1'b1
				&& mem.wdata === rq.wdata : mem.we_n === 1'b1 && mem.data_oe === 1'b0);
			cmp("bus in access", 1, ok);
			tail = 1'b1;
			cyc++;
		end else if (tail) begin
			cmp("hold cycle", 1, mem.addr === rq.addr && !stb && (!rq.write || mem.wdata === rq.wdata));
			tail = 1'b0;
		end
	end

	// Main sequence.
	initial begin
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		av(0, 8'h04, 0);
		cmp("reset word", 0, q);
		for (int i = 0; i < 16; i++) av(1, 8'(i * 4), wordv(i));
		for (int i = 0; i < 16; i++) begin
			av(0, 8'(i * 4), 0);
			cmp("timing word", wordv(i), q);
		end
		$display("done registers");
		for (int r = 0; r < 8; r++) begin
			acc(rows[r].wr, rows[r].bank, rows[r].be, 24'h01_0000 * r + 24'h35);
			cmp("strobe lead", rows[r].lead, fall);
			cmp("strobe width", rows[r].wid, wid);
			if (!rows[r].wr) cmp("read data", {8'ha5, rq.addr}, rs_d);
		end
		av(0, OFS_STATUS, 0);
		cmp("status", 32'he, q);
		av(1, 8'h48, 32'hffff_ffff);
		av(0, 8'h48, 0);
		cmp("unmapped", 0, q);
		$display("done rows");
		av(1, 8'h04, 32'h1f);
		fork
			acc(0, 0, 4'hf, 24'habcdef);
			begin
				repeat (4) @(posedge clk);
				av(1, 8'h04, 0);
			end
		join
		cmp("long width", 32, wid);
		acc(0, 0, 4'hf, 24'h123456);
		cmp("next width", 1, wid);
		$display("done sampling");
		@(posedge clk);
		nrst <= 1'b0;
		@(negedge clk);
		cmp("reset pins", {4'hf, 3'b111, 4'hf}, {mem.cs_n, mem.oe_n, mem.we_n, rq_rdy, mem.byte_lane_strobe_n});
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		av(0, 8'h08, 0);
		cmp("word after reset", 0, q);
		$display("done reset");
		wrap_up;
	end
endmodule : smct_top_test
`default_nettype wire
